/* File: scs_pkg.sv */
package scs_pkg;
   localparam int CLK_MHZ = 125;
   localparam int SYNC_LOW_NS = 500;
   localparam int SYNC_LOW_CYC = (SYNC_LOW_NS * CLK_MHZ) / 1000;
   // register byte offsets
   localparam logic [11:0] OFS_FREQ = 12'h000;
   localparam logic [11:0] OFS_PHASE = 12'h004;
   localparam logic [11:0] OFS_GLOBAL = 12'h008;
   localparam logic [11:0] OFS_PAD = 12'h00C;
   localparam logic [11:0] OFS_STAT = 12'h010;
   localparam logic [11:0] OFS_MASK = 12'h014;
   localparam logic [11:0] OFS_CTRL = 12'h018;
   // field positions
   localparam int GLB_SYNC_DIS_BIT = 4;
   localparam int GLB_EXT_CLK_BIT = 5;
   localparam int PH_SHARE_EA_BIT = 7;
   localparam int PAD_INT_NOOUT_BIT = 10;
   localparam int PAD_LOCKED_BIT = 0;
   localparam int PAD_EXT_PRESENT_BIT = 1;
   localparam int PAD_FAULT_BIT = 2;
   localparam int CTRL_SRC_CMD_BIT = 0;
   // status event bits
   localparam int EV_LOCK = 0;
   localparam int EV_LOSS = 1;
   localparam int EV_FAULT = 2;
   localparam int EV_REJECT = 3;
   localparam int EV_W = 4;
   // reset values
   localparam logic [15:0] FREQ_RST = 16'h03E8;
   localparam logic [7:0] PHASE_RST = 8'h00;
   localparam logic [7:0] GLOBAL_RST = 8'h00;
   // period field width and phase table resolution
   localparam int PER_W = 16;
   localparam int PH_SEL_W = 3;
   typedef enum logic [1:0] {
      SCS_INT = 2'b00,
      SCS_LOCKED = 2'b01,
      SCS_HOLD = 2'b10
   } scs_mode_type;
endpackage : scs_pkg

/* File: scs_osc_if.sv */
`timescale 1ns/1ps
// links the top to the period oscillator
interface scs_osc_if;
   logic [15:0] period;
   logic [15:0] offs0;
   logic [15:0] offs1;
   logic resync;
   logic tick;
   logic [15:0] count;
   logic tg0;
   logic tg1;
   modport top (output period, output offs0, output offs1, output resync,
      input tick, input count, input tg0, input tg1);
   modport osc (input period, input offs0, input offs1, input resync,
      output tick, output count, output tg0, output tg1);
endinterface : scs_osc_if

/* File: scs_osc.sv */
`timescale 1ns/1ps
module scs_osc
   import scs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   scs_osc_if.osc o
);
   logic [15:0] cnt_reg;
   // period counter, restarted by the lock loop on the sync falling edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 16'h0000;
      end else if (o.resync || cnt_reg >= o.period - 16'h0001) begin
         cnt_reg <= 16'h0000;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
   assign o.count = cnt_reg;
   assign o.tick = (cnt_reg == 16'h0000);
   // top gate rises at its offset from the period start, high half a period or until the period ends if that comes first
   assign o.tg0 = ((cnt_reg - o.offs0) & 16'h7FFF) < (o.period >> 1);
   assign o.tg1 = ((cnt_reg - o.offs1) & 16'h7FFF) < (o.period >> 1);
endmodule : scs_osc

/* File: scs_top.sv */
`timescale 1ns/1ps
module scs_top
   import scs_pkg::*;
#(
   parameter int LOSS_MULT = 2
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic run0,
   input wire logic run1,
   input wire logic [15:0] rate_strap_pin,
   input wire logic [2:0] phase_strap_pin,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe,
   output logic top_gate_out0,
   output logic top_gate_out1,
   output logic share_err_amp,
   output logic lock_fault,
   output logic irq
);
   initial begin
      if (LOSS_MULT < 1) $error("LOSS_MULT must be at least one");
   end

   scs_osc_if oi();
   scs_osc u_osc (.pclk(pclk), .presetn(presetn), .o(oi));

   logic [15:0] freq_reg;
   logic [7:0] phase_reg;
   logic [7:0] global_reg;
   logic [EV_W-1:0] stat_reg;
   logic [EV_W-1:0] mask_reg;
   logic [1:0] ctrl_reg;
   logic [2:0] strap_ph_reg;
   logic [15:0] strap_fr_reg;
   logic strap_done_reg;
   logic strap_arm_reg;
   logic [2:0] strap_ph_s;
   logic [15:0] strap_fr_s;
   logic [1:0] run0_s, run1_s;
   logic [2:0] sync_s;
   logic [16:0] ext_cnt_reg;
   logic [15:0] ext_per_reg;
   scs_mode_type mode_reg;
   logic [15:0] low_cnt_reg;
   logic [31:0] rdata_next;

   // pin synchronisers; only the second stage and later are read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run0_s <= 2'b00;
         run1_s <= 2'b00;
         sync_s <= 3'b111;
      end else begin
         run0_s <= {run0_s[0], run0};
         run1_s <= {run1_s[0], run1};
         sync_s <= {sync_s[1:0], sync_in};
      end
   end

   wire chans_idle = !run0_s[1] && !run1_s[1] && !ctrl_reg[1];
   wire sync_fall = sync_s[2] && !sync_s[1];
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;

   // straps pass a sampling stage, then are captured once after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_arm_reg <= 1'b0;
         strap_done_reg <= 1'b0;
         strap_ph_s <= 3'b000;
         strap_fr_s <= 16'h0000;
         strap_ph_reg <= 3'b000;
         strap_fr_reg <= 16'h0000;
      end else begin
         strap_ph_s <= phase_strap_pin;
         strap_fr_s <= rate_strap_pin;
         strap_arm_reg <= 1'b1;
         if (strap_arm_reg && !strap_done_reg) begin
            strap_done_reg <= 1'b1;
            strap_ph_reg <= strap_ph_s;
            strap_fr_reg <= strap_fr_s;
         end
      end
   end

   // sync disabled by stored global bit, or by strap code 7 while the straps are the source
   wire sync_dis = global_reg[GLB_SYNC_DIS_BIT] || (!ctrl_reg[CTRL_SRC_CMD_BIT]
      && strap_ph_reg == 3'b111);
   wire ext_mode = global_reg[GLB_EXT_CLK_BIT] || sync_dis;
   // frequency and phase sources chosen together by the one CTRL source bit
   wire [15:0] per_sel = ctrl_reg[CTRL_SRC_CMD_BIT] ? freq_reg : strap_fr_reg;
   wire [2:0] ph_sel = ctrl_reg[CTRL_SRC_CMD_BIT] ? phase_reg[2:0] : strap_ph_reg;
   wire no_freq = (per_sel == 16'h0000);

   function automatic logic [15:0] ph_offs(input logic [15:0] per, input logic [2:0] sel);
      ph_offs = 16'((32'(per) * 32'(sel)) >> PH_SEL_W);
   endfunction : ph_offs

   // register writes; frequency and phase only while stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_reg <= FREQ_RST;
         phase_reg <= PHASE_RST;
         global_reg <= GLOBAL_RST;
         mask_reg <= '0;
         ctrl_reg <= 2'b00;
      end else if (wr) begin
         case (paddr)
            OFS_FREQ: if (chans_idle) freq_reg <= pwdata[15:0];
            OFS_PHASE: if (chans_idle) phase_reg <= pwdata[7:0];
            OFS_GLOBAL: global_reg <= pwdata[7:0];
            OFS_MASK: mask_reg <= pwdata[EV_W-1:0];
            OFS_CTRL: ctrl_reg <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // measure external period; loss when no edge within LOSS_MULT periods
   wire [16:0] loss_lim = 17'(LOSS_MULT) * 17'(per_sel);
   wire ext_fast = ext_cnt_reg < 17'({per_sel, 1'b0});
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_cnt_reg <= '0;
         ext_per_reg <= '0;
      end else if (sync_fall) begin
         ext_cnt_reg <= '0;
         ext_per_reg <= ext_cnt_reg[15:0];
      end else if (ext_cnt_reg != 17'h1FFFF) begin
         ext_cnt_reg <= ext_cnt_reg + 17'h00001;
      end
   end
   // our own pulse must never count as a foreign clock, in holdover too
   wire own_edge = sync_oe;
   wire ext_edge = sync_fall && !own_edge && ext_fast;
   wire ext_lost = ext_cnt_reg > loss_lim;

   // lock state: internal, locked, or holdover after loss
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= SCS_INT;
      end else begin
         case (mode_reg)
            SCS_INT: if (ext_edge) mode_reg <= SCS_LOCKED;
            SCS_LOCKED: if (ext_lost) mode_reg <= SCS_HOLD;
            SCS_HOLD: if (ext_edge) mode_reg <= SCS_LOCKED;
            default: mode_reg <= SCS_INT;
         endcase
      end
   end

   wire [15:0] act_per = (mode_reg == SCS_LOCKED && ext_per_reg != 16'h0000) ?
      ext_per_reg : per_sel;
   assign oi.period = (act_per == 16'h0000) ? 16'hFFFF : act_per;
   assign oi.offs0 = 16'h0000;
   assign oi.offs1 = ph_offs(oi.period, ph_sel);
   assign oi.resync = (mode_reg == SCS_LOCKED) && sync_fall;

   // sync pulse driver; a started pulse runs its full length so the shared
   // line sees no runt, new pulses are held off in external mode or while locked
   wire pulse_ok = !ext_mode && mode_reg != SCS_LOCKED && !no_freq;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_reg <= '0;
         sync_oe <= 1'b0;
      end else if (low_cnt_reg != 16'h0000) begin
         low_cnt_reg <= low_cnt_reg - 16'h0001;
      end else if (oi.tick && pulse_ok) begin
         low_cnt_reg <= 16'(SYNC_LOW_CYC - 1);
         sync_oe <= 1'b1;
      end else begin
         sync_oe <= 1'b0;
      end
   end

   wire fault_now = no_freq && (mode_reg != SCS_LOCKED);
   wire pad_int_noout = ext_mode && (mode_reg != SCS_LOCKED);

   // registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_out <= 1'b0;
         top_gate_out0 <= 1'b0;
         top_gate_out1 <= 1'b0;
         share_err_amp <= 1'b0;
         lock_fault <= 1'b0;
         irq <= 1'b0;
      end else begin
         sync_out <= 1'b0;
         top_gate_out0 <= oi.tg0 && run0_s[1] && !ctrl_reg[1];
         top_gate_out1 <= oi.tg1 && run1_s[1] && !ctrl_reg[1];
         share_err_amp <= phase_reg[PH_SHARE_EA_BIT];
         lock_fault <= fault_now;
         irq <= |(stat_reg & mask_reg);
      end
   end

   // sticky events; set wins over clear-on-read
   logic [EV_W-1:0] ev;
   always_comb begin
      ev = '0;
      ev[EV_LOCK] = ext_edge && mode_reg != SCS_LOCKED;
      ev[EV_LOSS] = mode_reg == SCS_LOCKED && ext_lost;
      ev[EV_FAULT] = fault_now && !lock_fault;
      ev[EV_REJECT] = wr && !chans_idle && (paddr == OFS_FREQ || paddr == OFS_PHASE);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_reg <= '0;
      end else if (rd && paddr == OFS_STAT) begin
         stat_reg <= ev;
      end else begin
         stat_reg <= stat_reg | ev;
      end
   end

   // read mux
   always_comb begin
      rdata_next = 32'h00000000;
      case (paddr)
         OFS_FREQ: rdata_next[15:0] = freq_reg;
         OFS_PHASE: rdata_next[7:0] = phase_reg;
         OFS_GLOBAL: rdata_next[7:0] = global_reg;
         OFS_PAD: begin
            rdata_next[PAD_INT_NOOUT_BIT] = pad_int_noout;
            rdata_next[PAD_LOCKED_BIT] = mode_reg == SCS_LOCKED;
            rdata_next[PAD_EXT_PRESENT_BIT] = !ext_lost;
            rdata_next[PAD_FAULT_BIT] = lock_fault;
         end
         OFS_STAT: rdata_next[EV_W-1:0] = stat_reg;
         OFS_MASK: rdata_next[EV_W-1:0] = mask_reg;
         OFS_CTRL: rdata_next[1:0] = ctrl_reg;
         default: rdata_next = 32'h00000000;
      endcase
   end

   // APB answer: one setup plus a zero-wait access; data registered
   wire mapped = paddr inside {OFS_FREQ, OFS_PHASE, OFS_GLOBAL, OFS_PAD, OFS_STAT,
      OFS_MASK, OFS_CTRL};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= rdata_next;
         pready <= 1'b1;
         pslverr <= !mapped;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule : scs_top

/* File: scs_properties.sv */
`timescale 1ns/1ps
module scs_properties
   import scs_pkg::*;
#(
   parameter int LOSS_MULT = 2
)(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sync_out,
   input wire logic sync_oe,
   input wire logic top_gate_out0,
   input wire logic run0,
   input wire logic share_err_amp
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   int low_cnt;
   // length of the sync low pulse under way
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) low_cnt <= 0;
      else low_cnt <= sync_oe ? low_cnt + 1 : 0;
   end
   chk_ready_zero_wait: assert property (psel && penable |-> pready)
      else $error("pready missing in access cycle");
   chk_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access cycle");
   chk_unmapped_err: assert property (psel && penable |-> pslverr == (paddr > OFS_CTRL))
      else $error("pslverr wrong for address");
   chk_sync_open_drain: assert property (sync_out == 1'b0)
      else $error("sync driven high");
   chk_pulse_width: assert property ($fell(sync_oe) |-> low_cnt == SYNC_LOW_CYC)
      else $error("sync low pulse length wrong");
   chk_pulse_bound: assert property (low_cnt <= SYNC_LOW_CYC)
      else $error("sync low pulse too long");
   chk_share_write: assert property ($changed(share_err_amp) |->
      $past(psel && penable && pwrite && paddr == OFS_PHASE, 2))
      else $error("shared amplifier changed without write");
   chk_gate_phase: assert property ($rose(sync_oe) && $past(run0, 2) |->
      ##[0:3] top_gate_out0)
      else $error("channel 0 gate not started at sync fall");
   cover property ($fell(sync_oe));
   cover property (pslverr);
   cover property ($rose(share_err_amp));
endmodule : scs_properties

bind scs_top scs_properties #(.LOSS_MULT(LOSS_MULT)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
   .pslverr(pslverr), .sync_out(sync_out), .sync_oe(sync_oe),
   .top_gate_out0(top_gate_out0), .run0(run0), .share_err_amp(share_err_amp));

/* File: scs_sync_partner.sv */
`timescale 1ns/1ps
module scs_sync_partner (
   input wire logic run,
   output logic pull
);
   initial pull = 1'b0;
   // free-running oscillator, 125 ns period, released while stopped
   always begin
      #62.5;
      pull = run ? !pull : 1'b0;
   end
endmodule : scs_sync_partner

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import scs_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdata;
   logic pready, pslverr, last_err, sync_out, sync_oe, ext_pull, tg0, tg1, share, fault, irq;
   logic run0 = 1'b0, run1 = 1'b0, ext_run = 1'b0;
   logic [2:0] watch_d = '0;
   wire [2:0] watch = {tg1, tg0, sync_oe};
   wire sync_wire = !(sync_oe || ext_pull); // pulled up when nobody pulls
   int err_total = 0, total_checks = 0, cyc = 0, a, b;
   always #4 pclk = !pclk;
   // cycle count and edge history
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      watch_d <= watch;
   end
   scs_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .run0(run0), .run1(run1), .rate_strap_pin(16'h00A0),
      .phase_strap_pin(3'h2), .sync_in(sync_wire), .sync_out(sync_out), .sync_oe(sync_oe),
      .top_gate_out0(tg0), .top_gate_out1(tg1), .share_err_amp(share), .lock_fault(fault),
      .irq(irq));
   scs_sync_partner ext (.run(ext_run), .pull(ext_pull));
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      if (n == 50) err_total++;
      rdata = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rise(input int i, output int t);
      int n;
      n = 0;
      @(posedge pclk);
      while (!(watch[i] === 1'b1 && watch_d[i] === 1'b0) && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 3000) err_total++; // no edge seen in time
      t = cyc;
   endtask : rise
   task rises(input int i, output int cnt);
      cnt = 0;
      repeat (400) begin
         @(posedge pclk);
         if (watch[i] === 1'b1 && watch_d[i] === 1'b0) cnt++;
      end
   endtask : rises
   task gap(input int i, input int j, input int exp, input string name);
      rise(i, a);
      rise(j, b);
      check(name, b - a, exp);
   endtask : gap
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop
   // hang guard
   initial begin
      #400000;
      err_total++;
      report_and_stop;
   end
   // main sequence
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, OFS_FREQ, '0);
      check("freq", rdata, FREQ_RST);
      apb(0, 12'h020, '0);
      check("unmapped", {last_err, rdata[30:0]}, 32'h80000000);
      gap(0, 0, 160, "strap period");
      // gates switch only while channels run; let a full period settle first
      run0 <= 1'b1;
      run1 <= 1'b1;
      repeat (400) @(posedge pclk);
      gap(1, 2, 40, "strap phase");
      run0 <= 1'b0;
      run1 <= 1'b0;
      repeat (4) @(posedge pclk);
      // commands: half a turn apart for a two-phase rail, shared amplifier
      apb(1, OFS_FREQ, 32'h000000C8);
      apb(1, OFS_PHASE, 32'h00000084);
      apb(1, OFS_CTRL, 32'h00000001);
      gap(0, 0, 200, "cmd period");
      run0 <= 1'b1;
      run1 <= 1'b1;
      repeat (400) @(posedge pclk);
      gap(1, 2, 100, "cmd phase");
      check("share", share, 1);
      // writes while a channel runs are dropped, flagged, masked or not
      for (int m = 0; m < 2; m++) begin
         apb(1, OFS_MASK, m * 8);
         run0 <= m == 0;
         run1 <= m == 1;
         repeat (4) @(posedge pclk);
         apb(1, OFS_FREQ, 32'h00000064);
         apb(1, OFS_PHASE, '0);
         repeat (2) @(posedge pclk);
         check("irq", irq, m);
         apb(0, OFS_FREQ, '0);
         check("freq kept", rdata, 32'h000000C8);
         apb(0, OFS_PHASE, '0);
         check("phase kept", rdata, 32'h00000084);
         apb(0, OFS_STAT, '0);
         check("rejected", rdata[EV_REJECT], 1);
         repeat (2) @(posedge pclk);
         check("irq clear", irq, 0);
      end
      run0 <= 1'b0;
      run1 <= 1'b0;
      // sync output off by global setup bit 4 or external mode
      for (int g = 4; g < 6; g++) begin
         apb(1, OFS_GLOBAL, 32'h1 << g);
         repeat (2) @(posedge pclk);
         rises(0, a);
         check("sync pulses", a, 0);
         apb(0, OFS_PAD, '0);
         check("internal no output", rdata[10], 1);
      end
      apb(1, OFS_GLOBAL, '0);
      gap(0, 0, 200, "sync period");
      // external clock takes over, then goes away
      ext_run <= 1'b1;
      repeat (300) @(posedge pclk);
      rises(0, a);
      check("driving while locked", a, 0);
      apb(0, OFS_PAD, '0);
      check("locked", rdata[0], 1);
      ext_run <= 1'b0;
      run0 <= 1'b1;
      repeat (600) @(posedge pclk);
      rises(1, a);
      check("still switching", a > 0, 1);
      apb(0, OFS_STAT, '0);
      check("lock and loss", rdata[1:0], 3);
      // no frequency and no external clock
      run0 <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1, OFS_FREQ, '0);
      repeat (20) @(posedge pclk);
      check("lock fault", fault, 1);
      report_and_stop;
   end
endmodule : tb_top
